// >>> src/gpio_wake_event_led.sv
`timescale 1ns/100ps
// Behaviour
// - Wake status sets on the edge chosen by polarity, rising by default.
// - Wake event needs status, pin enable and global enable all set.
// - Writing one clears a wake status bit; zero leaves it alone.
// - Wake bits group pins into sets two, three, four, five and seven.
// - Interrupt bits group pins into sets three, four, five, seven; pin 23 none.
// - Pins 21, 22, 41, 43, 60, 61 detect both edges.
// - Either-edge mode ignores direction, polarity, output type; polarity inverts readback.
// - Either-edge pin raises events only in that mode with enable set.
// - Misc status collects all either-edge bits, set on any edge, write-one-clear.
// - Status bits record edges regardless of enables or either-edge mode.
// - Fan pin drives low after main reset; non-inverting output without main supply.
// - IR transmit pin drives low after any reset and without main supply.
// - Pin 43 selects its general-purpose function after main or hard reset.
// - LED pins 60, 61 get on, off, blink via registers 0x5D, 0x5E.
// - Blink timed by the slow clock; no slow clock means no blinking.
// - Pin 61 powers up in LED mode blinking at 1 Hz, half duty.
// - LED control keeps working on standby supply in open-drain or push-pull.
// - Register block decodes at the I/O base from configuration registers.
// - Control bit 0 direction, bit 1 inversion, bit 7 output type.
module gpio_wake_event_led #(
  parameter int BLINK_HALF = gpio_wake_pkg::BLINK_HALF_TICKS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire gpio_wake_pkg::avReq_t avReq,
  output gpio_wake_pkg::avRsp_t avRsp,
  input wire logic [15:0] ioBase,
  input wire logic [35:0] pinIn,
  output logic [35:0] pinOut,
  output logic [35:0] pinOe_n,
  input wire logic slowClkIn,
  input wire logic mainSupplyOk,
  input wire logic hardReset_n,
  output logic wakeEvent,
  output logic sysintEvent
);

  localparam int NPIN = gpio_wake_pkg::NPIN;

  logic [38:0] sync1_q, sync2_q, sync3_q, level_q;
  logic [38:0] change, syncIn;
  logic [35:0] rise, fall;
  logic [7:0] ctrl_q [36];
  logic [35:0] data_q, wakeSts_q, wakeSts_d, wakeEn_q, sysSts_q, sysSts_d, sysEn_q;
  logic [35:0] wakeQual, wakeHit, wakeClr, sysClr, pinOut_q, pinOeN_q;
  logic [5:0] miscSts_q, miscSts_d, miscHit;
  logic [7:0] ledOne_q, ledTwo_q;
  logic wakeGlobal_q, wakeEvent_q, sysintEvent_q, blink_q, slowTick, mainOk, mainRstEvt;
  logic [14:0] blinkCnt_q;
  gpio_wake_pkg::avRsp_t rsp_q;
  logic [15:0] offset;
  logic [7:0] regIdx;
  logic hit, wrStb;
  logic [31:0] wrData, rdMux;

  // Three-stage synchroniser; a change counts once stages two and three agree.
  assign syncIn = {hardReset_n, mainSupplyOk, slowClkIn, pinIn};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      level_q <= '0;
    end else begin
      sync1_q <= syncIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= (sync2_q ~^ sync3_q) & sync3_q | ~(sync2_q ~^ sync3_q) & level_q;
    end
  end

  // The accepted level changes exactly once per qualified transition.
  assign change = (sync2_q ~^ sync3_q) & (sync3_q ^ level_q);
  assign rise = change[35:0] & sync3_q[35:0];
  assign fall = change[35:0] & ~sync3_q[35:0];
  assign slowTick = change[gpio_wake_pkg::SYNC_SLOW] & sync3_q[gpio_wake_pkg::SYNC_SLOW];
  assign mainOk = level_q[gpio_wake_pkg::SYNC_MAIN];
  // Main reset is a hard reset falling or the main supply coming up.
  assign mainRstEvt = (change[gpio_wake_pkg::SYNC_HRST] & ~sync3_q[gpio_wake_pkg::SYNC_HRST])
                    | (change[gpio_wake_pkg::SYNC_MAIN] & sync3_q[gpio_wake_pkg::SYNC_MAIN]);

  // Window decode relative to the I/O base held in configuration space.
  assign offset = avReq.address[17:2] - ioBase;
  assign hit = (offset[15:8] == 8'h00);
  assign regIdx = offset[7:0];
  assign wrStb = avReq.write & ~rsp_q.waitrequest & hit;
  assign wrData = avReq.writedata & {{8{avReq.byteenable[3]}}, {8{avReq.byteenable[2]}},
                                     {8{avReq.byteenable[1]}}, {8{avReq.byteenable[0]}}};

  function automatic logic laneOk(input logic [3:0] bitPos, input logic [3:0] be);
    return bitPos[3] ? be[1] : be[0];
  endfunction : laneOk

  function automatic logic inMode(input logic [7:0] c, input int p);
    return c[gpio_wake_pkg::CTRL_DIR] | (gpio_wake_pkg::EE_MASK[p] & c[gpio_wake_pkg::CTRL_EE]);
  endfunction : inMode

  // Edge qualification, write-one clears, and set winning over clear.
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      wakeQual[p] = ~gpio_wake_pkg::EE_MASK[p] | ctrl_q[p][gpio_wake_pkg::CTRL_EE];
      if (wakeQual[p] && gpio_wake_pkg::EE_MASK[p]) begin
        wakeHit[p] = rise[p] | fall[p];
      end else begin
        wakeHit[p] = ctrl_q[p][gpio_wake_pkg::CTRL_POL] ? fall[p] : rise[p];
      end
      wakeClr[p] = wrStb
                 && regIdx == gpio_wake_pkg::IDX_WAKE_STS_BASE + {5'h00, gpio_wake_pkg::wakeSet(p)}
                 && wrData[gpio_wake_pkg::wakeBit(p)];
      sysClr[p] = wrStb
                && regIdx == gpio_wake_pkg::IDX_SYS_STS_BASE + {5'h00, gpio_wake_pkg::sysSet(p)}
                && wrData[gpio_wake_pkg::sysBit(p)];
    end
    for (int i = 0; i < gpio_wake_pkg::NEE; i++) begin
      miscHit[i] = change[gpio_wake_pkg::eePin(i)];
    end
    wakeSts_d = (wakeSts_q & ~wakeClr) | wakeHit;
    sysSts_d = ((sysSts_q & ~sysClr) | wakeHit) & gpio_wake_pkg::SYS_MASK;
    miscSts_d = (miscSts_q & ~(wrStb && regIdx == gpio_wake_pkg::IDX_MISC_STS ? wrData[5:0]
                                                                              : 6'h00)) | miscHit;
  end

  // Status registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeSts_q <= '0;
      sysSts_q <= '0;
      miscSts_q <= '0;
    end else begin
      wakeSts_q <= wakeSts_d;
      sysSts_q <= sysSts_d;
      miscSts_q <= miscSts_d;
    end
  end

  // Enable registers, written lane by lane through the same bit mapping.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeEn_q <= '0;
      sysEn_q <= '0;
      wakeGlobal_q <= 1'b0;
    end else if (wrStb) begin
      for (int p = 0; p < NPIN; p++) begin
        if (regIdx == gpio_wake_pkg::IDX_WAKE_EN_BASE + {5'h00, gpio_wake_pkg::wakeSet(p)}
            && laneOk(gpio_wake_pkg::wakeBit(p), avReq.byteenable)) begin
          wakeEn_q[p] <= avReq.writedata[gpio_wake_pkg::wakeBit(p)];
        end
        if (gpio_wake_pkg::SYS_MASK[p]
            && regIdx == gpio_wake_pkg::IDX_SYS_EN_BASE + {5'h00, gpio_wake_pkg::sysSet(p)}
            && laneOk(gpio_wake_pkg::sysBit(p), avReq.byteenable)) begin
          sysEn_q[p] <= avReq.writedata[gpio_wake_pkg::sysBit(p)];
        end
      end
      if (regIdx == gpio_wake_pkg::IDX_WAKE_GLOBAL && avReq.byteenable[0]) begin
        wakeGlobal_q <= avReq.writedata[0];
      end
    end
  end

  // Group outputs. Pin 27's interrupt enable is left to software discipline.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeEvent_q <= 1'b0;
      sysintEvent_q <= 1'b0;
    end else begin
      wakeEvent_q <= wakeGlobal_q & |(wakeSts_q & wakeEn_q & wakeQual);
      sysintEvent_q <= |(sysSts_q & sysEn_q & wakeQual);
    end
  end

  // Pin control registers; main reset restores the fan and IR transmit pins' defaults and clears pin 43's either-edge bit.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NPIN; p++) begin
        ctrl_q[p] <= gpio_wake_pkg::CTRL_RST_INPUT;
      end
      ctrl_q[gpio_wake_pkg::PIN_FAN] <= gpio_wake_pkg::CTRL_RST_DRIVE_LOW;
      ctrl_q[gpio_wake_pkg::PIN_IRTX] <= gpio_wake_pkg::CTRL_RST_DRIVE_LOW;
      ctrl_q[gpio_wake_pkg::PIN_LED_B] <= gpio_wake_pkg::CTRL_RST_LED;
    end else if (mainRstEvt) begin
      ctrl_q[gpio_wake_pkg::PIN_FAN] <= gpio_wake_pkg::CTRL_RST_DRIVE_LOW;
      ctrl_q[gpio_wake_pkg::PIN_IRTX] <= gpio_wake_pkg::CTRL_RST_DRIVE_LOW;
      ctrl_q[gpio_wake_pkg::PIN_FOUR_THREE][gpio_wake_pkg::CTRL_EE] <= 1'b0;
    end else if (wrStb && avReq.byteenable[0]) begin
      for (int p = 0; p < NPIN; p++) begin
        if (regIdx == gpio_wake_pkg::IDX_CTRL_BASE + 8'(p)) begin
          // Mode bits stick only on pins that have the mode.
          ctrl_q[p] <= avReq.writedata[7:0]
                     & ~(gpio_wake_pkg::EE_MASK[p] ? 8'h00 : 8'h04)
                     & ~(p >= gpio_wake_pkg::PIN_LED_A ? 8'h00 : 8'h08);
        end
      end
    end
  end

  // Output data; writes to pins in input mode have no effect.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_q <= '0;
    end else if (mainRstEvt) begin
      data_q[gpio_wake_pkg::PIN_FAN] <= 1'b0;
      data_q[gpio_wake_pkg::PIN_IRTX] <= 1'b0;
    end else if (wrStb && avReq.byteenable[0]) begin
      for (int p = 0; p < NPIN; p++) begin
        if (regIdx == gpio_wake_pkg::IDX_DATA_BASE + 8'(p / 8) && !inMode(ctrl_q[p], p)) begin
          data_q[p] <= avReq.writedata[p % 8];
        end
      end
    end
  end

  // LED control registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ledOne_q <= gpio_wake_pkg::LED_ONE_RST;
      ledTwo_q <= gpio_wake_pkg::LED_TWO_RST;
    end else if (wrStb && avReq.byteenable[0]) begin
      if (regIdx == gpio_wake_pkg::IDX_LED_ONE) begin
        ledOne_q <= avReq.writedata[7:0];
      end
      if (regIdx == gpio_wake_pkg::IDX_LED_TWO) begin
        ledTwo_q <= avReq.writedata[7:0];
      end
    end
  end

  // Blink phase advances only on slow clock edges, so a dead clock freezes it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blinkCnt_q <= '0;
      blink_q <= 1'b0;
    end else if (slowTick) begin
      if (blinkCnt_q == 15'(BLINK_HALF - 1)) begin
        blinkCnt_q <= '0;
        blink_q <= ~blink_q;
      end else begin
        blinkCnt_q <= blinkCnt_q + 15'h0001;
      end
    end
  end

  // Pad drive. Only standby-powered pads keep driving when main supply is gone.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut_q <= '0;
      pinOeN_q <= '1;
      pinOeN_q[gpio_wake_pkg::PIN_FAN] <= 1'b0;
      pinOeN_q[gpio_wake_pkg::PIN_IRTX] <= 1'b0;
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        logic [1:0] mode;
        logic v, od;
        mode = (p == gpio_wake_pkg::PIN_LED_A) ? ledOne_q[1:0] : ledTwo_q[1:0];
        od = ~ctrl_q[p][gpio_wake_pkg::CTRL_OTYPE];
        v = data_q[p] ^ ctrl_q[p][gpio_wake_pkg::CTRL_POL];
        if (p >= gpio_wake_pkg::PIN_LED_A && ctrl_q[p][gpio_wake_pkg::CTRL_LED]) begin
          v = (mode == gpio_wake_pkg::LED_MODE_ON)
            | ((mode == gpio_wake_pkg::LED_MODE_BLINK) & blink_q);
          pinOut_q[p] <= od ? 1'b0 : v;
          pinOeN_q[p] <= od ? ~v : 1'b0;
        end else if (p == gpio_wake_pkg::PIN_IRTX && !mainOk) begin
          pinOut_q[p] <= 1'b0;
          pinOeN_q[p] <= 1'b0;
        end else if (p == gpio_wake_pkg::PIN_FAN && !mainOk) begin
          pinOut_q[p] <= data_q[p];
          pinOeN_q[p] <= 1'b0;
        end else if (inMode(ctrl_q[p], p) || !mainOk) begin
          pinOut_q[p] <= 1'b0;
          pinOeN_q[p] <= 1'b1;
        end else begin
          pinOut_q[p] <= od ? 1'b0 : v;
          pinOeN_q[p] <= od ? v : 1'b0;
        end
      end
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    rdMux = '0;
    if (hit) begin
      for (int p = 0; p < NPIN; p++) begin
        if (regIdx == gpio_wake_pkg::IDX_CTRL_BASE + 8'(p)) begin
          rdMux[7:0] = ctrl_q[p];
        end
        if (regIdx == gpio_wake_pkg::IDX_DATA_BASE + 8'(p / 8)) begin
          rdMux[p % 8] = inMode(ctrl_q[p], p)
                       ? level_q[p] ^ ctrl_q[p][gpio_wake_pkg::CTRL_POL] : data_q[p];
        end
        if (regIdx == gpio_wake_pkg::IDX_WAKE_STS_BASE + {5'h00, gpio_wake_pkg::wakeSet(p)}) begin
          rdMux[gpio_wake_pkg::wakeBit(p)] = wakeSts_q[p];
        end
        if (regIdx == gpio_wake_pkg::IDX_WAKE_EN_BASE + {5'h00, gpio_wake_pkg::wakeSet(p)}) begin
          rdMux[gpio_wake_pkg::wakeBit(p)] = wakeEn_q[p];
        end
        if (gpio_wake_pkg::SYS_MASK[p]
            && regIdx == gpio_wake_pkg::IDX_SYS_STS_BASE + {5'h00, gpio_wake_pkg::sysSet(p)}) begin
          rdMux[gpio_wake_pkg::sysBit(p)] = sysSts_q[p];
        end
        if (gpio_wake_pkg::SYS_MASK[p]
            && regIdx == gpio_wake_pkg::IDX_SYS_EN_BASE + {5'h00, gpio_wake_pkg::sysSet(p)}) begin
          rdMux[gpio_wake_pkg::sysBit(p)] = sysEn_q[p];
        end
      end
      if (regIdx == gpio_wake_pkg::IDX_MISC_STS) begin
        rdMux[5:0] = miscSts_q;
      end
      if (regIdx == gpio_wake_pkg::IDX_WAKE_GLOBAL) begin
        rdMux[0] = wakeGlobal_q;
      end
      if (regIdx == gpio_wake_pkg::IDX_LED_ONE) begin
        rdMux[7:0] = ledOne_q;
      end
      if (regIdx == gpio_wake_pkg::IDX_LED_TWO) begin
        rdMux[7:0] = ledTwo_q;
      end
    end
  end

  // Bus slave: one wait cycle, then waitrequest low for exactly one cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_q <= '{readdata: 32'h00000000, waitrequest: 1'b1};
    end else if ((avReq.read || avReq.write) && rsp_q.waitrequest) begin
      rsp_q.waitrequest <= 1'b0;
      rsp_q.readdata <= avReq.read ? rdMux : 32'h00000000;
    end else begin
      rsp_q.waitrequest <= 1'b1;
    end
  end

  assign avRsp = rsp_q;
  assign pinOut = pinOut_q;
  assign pinOe_n = pinOeN_q;
  assign wakeEvent = wakeEvent_q;
  assign sysintEvent = sysintEvent_q;

  a_rise_sets_wake: assert property (@(posedge clk) disable iff (!arst_n)
    (rise[0] && !ctrl_q[0][gpio_wake_pkg::CTRL_POL]) |=> wakeSts_q[0])
    else $error("Rising edge did not set wake status.");

  a_wake_global_gate: assert property (@(posedge clk) disable iff (!arst_n)
    !wakeGlobal_q |=> !wakeEvent_q)
    else $error("Wake event raised with global enable off.");

  a_clear_on_one: assert property (@(posedge clk) disable iff (!arst_n)
    (wrStb && regIdx == gpio_wake_pkg::IDX_WAKE_STS_BASE + 8'h02 && wrData[0] && !wakeHit[0])
    |=> !wakeSts_q[0])
    else $error("Write of one did not clear wake status.");

  a_misc_both_edges: assert property (@(posedge clk) disable iff (!arst_n)
    (fall[9] || rise[9])
    |=> miscSts_q[0] && (sysSts_q[9] || !$past(ctrl_q[9][gpio_wake_pkg::CTRL_EE])))
    else $error("Edge on either-edge pin not recorded.");

  a_ee_no_drive: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_q[9][gpio_wake_pkg::CTRL_EE] |=> pinOeN_q[9])
    else $error("Either-edge pin is being driven.");

  a_ee_gates_event: assert property (@(posedge clk) disable iff (!arst_n)
    (!ctrl_q[9][gpio_wake_pkg::CTRL_EE] && (sysSts_q & sysEn_q) == 36'h000000200)
    |=> !sysintEvent_q)
    else $error("Either-edge pin raised interrupt outside its mode.");

  a_fan_low_reset: assert property (@(posedge clk) disable iff (!arst_n)
    (mainRstEvt ##1 (!wrStb && mainOk)) |=> (!pinOut_q[19] && !pinOeN_q[19]))
    else $error("Fan pin not driven low after main reset.");

  a_irtx_standby_low: assert property (@(posedge clk) disable iff (!arst_n)
    !mainOk |=> (!pinOut_q[27] && !pinOeN_q[27]))
    else $error("IR transmit pin not low on standby.");

  a_blink_frozen: assert property (@(posedge clk) disable iff (!arst_n)
    !slowTick |=> $stable(blink_q))
    else $error("Blink phase moved without a slow clock edge.");

  a_bus_one_wait: assert property (@(posedge clk) disable iff (!arst_n)
    ((avReq.read || avReq.write) && rsp_q.waitrequest) |=> !rsp_q.waitrequest ##1 rsp_q.waitrequest)
    else $error("Bus answer not one wait cycle then one ready cycle.");

endmodule : gpio_wake_event_led

// >>> src/gpio_wake_pkg.sv
package gpio_wake_pkg;

  // Pin vector order: 0-7 pins 10-17, 8-15 pins 20-27, 16-23 pins 30-37,
  // 24-31 pins 50-57, then 32 pin 41, 33 pin 43, 34 pin 60, 35 pin 61.
  localparam int NPIN = 36;
  localparam int NEE = 6;
  localparam int PIN_FAN = 19;
  localparam int PIN_IRTX = 27;
  localparam int PIN_FOUR_THREE = 33;
  localparam int PIN_LED_A = 34;
  localparam int PIN_LED_B = 35;
  localparam logic [35:0] EE_MASK = 36'hF00000600;
  localparam logic [35:0] SYS_MASK = 36'hFFFFFF7FF;

  // Synchroniser vector: pins first, then slow clock, main supply, hard reset.
  localparam int SYNC_SLOW = 36;
  localparam int SYNC_MAIN = 37;
  localparam int SYNC_HRST = 38;
  localparam int SYNC_W = 39;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_DATA_BASE = 8'h20;
  localparam logic [7:0] IDX_WAKE_STS_BASE = 8'h30;
  localparam logic [7:0] IDX_WAKE_EN_BASE = 8'h38;
  localparam logic [7:0] IDX_SYS_STS_BASE = 8'h40;
  localparam logic [7:0] IDX_SYS_EN_BASE = 8'h48;
  localparam logic [7:0] IDX_MISC_STS = 8'h50;
  localparam logic [7:0] IDX_WAKE_GLOBAL = 8'h51;
  localparam logic [7:0] IDX_LED_ONE = 8'h5D;
  localparam logic [7:0] IDX_LED_TWO = 8'h5E;
  localparam logic [7:0] IDX_CTRL_BASE = 8'h80;

  // Pin control register fields.
  localparam int CTRL_DIR = 0;
  localparam int CTRL_POL = 1;
  localparam int CTRL_EE = 2;
  localparam int CTRL_LED = 3;
  localparam int CTRL_OTYPE = 7;
  localparam logic [7:0] CTRL_RST_INPUT = 8'h01;
  localparam logic [7:0] CTRL_RST_DRIVE_LOW = 8'h00;
  localparam logic [7:0] CTRL_RST_LED = 8'h09;

  // LED control register modes in bits 1:0.
  localparam logic [1:0] LED_MODE_OFF = 2'h0;
  localparam logic [1:0] LED_MODE_ON = 2'h1;
  localparam logic [1:0] LED_MODE_BLINK = 2'h2;
  localparam logic [7:0] LED_ONE_RST = 8'h00;
  localparam logic [7:0] LED_TWO_RST = 8'h02;

  // Blink timing in slow clock ticks.
  localparam int SLOW_HZ = 32768;
  localparam int BLINK_HZ = 1;
  localparam int BLINK_HALF_TICKS = SLOW_HZ / (2 * BLINK_HZ);

  typedef struct packed {
    logic read;
    logic write;
    logic [17:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avReq_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avRsp_t;

  // Wake register set that holds a pin.
  function automatic logic [2:0] wakeSet(input int p);
    if (p < 8) return 3'h2;
    if (p < 16) return 3'h3;
    if (p < 20) return 3'h4;
    if (p < 24) return 3'h7;
    if (p < 32) return 3'h5;
    return 3'h4;
  endfunction : wakeSet

  function automatic logic [3:0] wakeBit(input int p);
    if (p < 16) return 4'(p % 8);
    if (p < 20) return 4'(p - 16);
    if (p < 24) return 4'(p - 20);
    if (p < 32) return 4'(p - 24);
    return 4'(p - 28);
  endfunction : wakeBit

  // Interrupt register set that holds a pin; zero means none.
  function automatic logic [2:0] sysSet(input int p);
    if (p < 8) return 3'h5;
    if (p == 11) return 3'h0;
    if (p < 16) return 3'h3;
    if (p < 20) return 3'h4;
    if (p < 24) return 3'h7;
    if (p < 32) return 3'h5;
    if (p == PIN_LED_A) return 3'h3;
    return 3'h4;
  endfunction : sysSet

  function automatic logic [3:0] sysBit(input int p);
    if (p < 8) return 4'(p + 8);
    if (p < 16) return 4'(p - 8);
    if (p < 20) return 4'(p - 16);
    if (p < 24) return 4'(p - 20);
    if (p < 32) return 4'(p - 24);
    if (p == PIN_LED_A) return 4'h3;
    if (p == PIN_LED_B) return 4'h6;
    return 4'(p - 28);
  endfunction : sysBit

  function automatic int eePin(input int i);
    if (i < 2) return 9 + i;
    return 30 + i;
  endfunction : eePin

endpackage : gpio_wake_pkg

// >>> tb/gpio_wake_event_led_bench.sv
`timescale 1ns/100ps
module gpio_wake_event_led_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  gpio_wake_pkg::avReq_t avReq = '0;
  gpio_wake_pkg::avRsp_t avRsp;
  logic [35:0] want = '0;
  logic [35:0] pinIn, pinOut, pinOe_n;
  logic slowOn = 1'b0;
  logic mainOk = 1'b0;
  logic hardRst_n = 1'b1;
  logic slowClk, wakeEvent, sysintEvent;
  logic [31:0] rd;
  int fails = 0;
  int checked = 0;
  int flips;
  localparam logic [15:0] BASE = 16'h0010;
  always #5 clk = ~clk;
  // A short blink half period keeps the run brief.
  gpio_wake_event_led #(.BLINK_HALF(4)) gpio_wake_event_led_i (.clk(clk), .arst_n(arst_n),
    .avReq(avReq), .avRsp(avRsp), .ioBase(BASE), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe_n(pinOe_n), .slowClkIn(slowClk), .mainSupplyOk(mainOk), .hardReset_n(hardRst_n),
    .wakeEvent(wakeEvent), .sysintEvent(sysintEvent));
  pin_partner pin_partner_i (.clk(clk), .want(want), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .slowOn(slowOn), .pinIn(pinIn), .slowClk(slowClk));
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus access; the request stands until waitrequest is sampled low.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avReq.read <= ~wr;
    avReq.write <= wr;
    avReq.address <= {BASE + 16'(idx), 2'b00};
    avReq.writedata <= {16'h0000, wd};
    avReq.byteenable <= 4'h3;
    do begin
      @(posedge clk);
      n++;
    end while (avRsp.waitrequest !== 1'b0 && n < 20);
    rd = avRsp.readdata;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
    if (n >= 20) begin
      fails++;
      wrap_up();
    end
  endtask : xfer
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 16'h0000);
    chk(rd, exp);
  endtask : rchk
  // The pad change needs the synchroniser plus two cycles to show.
  task automatic pins(input int p, input logic v);
    want[p] <= v;
    repeat (8) @(posedge clk);
  endtask : pins
  task automatic count(input int n);
    logic prev;
    flips = 0;
    prev = pinOe_n[35];
    repeat (n) begin
      @(posedge clk);
      if (pinOe_n[35] !== prev) flips++;
      prev = pinOe_n[35];
    end
  endtask : count
  // Main sequence: reset values, wake edges, either-edge pin, LEDs.
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    mainOk <= 1'b1;
    repeat (8) @(posedge clk);
    chk({30'h0, pinOut[27], pinOe_n[27]}, 32'h0);
    rchk(8'h5D, 32'h00);
    rchk(8'h5E, 32'h02);
    rchk(8'hA3, 32'h09);
    rchk(8'h93, 32'h00);
    rchk(8'hA1, 32'h01);
    $display("test reset done");
    xfer(1'b1, 8'h3A, 16'h0001);
    xfer(1'b1, 8'h51, 16'h0001);
    pins(0, 1'b1);
    rchk(8'h32, 32'h1);
    chk({31'h0, wakeEvent}, 32'h1);
    rchk(8'h45, 32'h100);
    xfer(1'b1, 8'h32, 16'h0000);
    rchk(8'h32, 32'h1);
    xfer(1'b1, 8'h32, 16'h0001);
    rchk(8'h32, 32'h0);
    chk({31'h0, wakeEvent}, 32'h0);
    xfer(1'b1, 8'h80, 16'h0003);
    pins(0, 1'b0);
    rchk(8'h20, 32'h1);
    rchk(8'h32, 32'h1);
    $display("test wake edges done");
    pins(9, 1'b1);
    rchk(8'h50, 32'h1);
    xfer(1'b1, 8'h89, 16'h0007);
    xfer(1'b1, 8'h3B, 16'h0002);
    xfer(1'b1, 8'h4B, 16'h0002); // Bit 7 stays clear while pin 27 is the group output.
    xfer(1'b1, 8'h33, 16'h00FF);
    xfer(1'b1, 8'h43, 16'h00FF);
    xfer(1'b1, 8'h50, 16'h00FF);
    pins(9, 1'b0);
    rchk(8'h50, 32'h1);
    rchk(8'h43, 32'h2);
    chk({30'h0, wakeEvent, sysintEvent}, 32'h3);
    rchk(8'h21, 32'h2);
    xfer(1'b1, 8'h89, 16'h0001);
    xfer(1'b1, 8'h43, 16'h00FF);
    pins(9, 1'b1);
    rchk(8'h43, 32'h2);
    chk({31'h0, sysintEvent}, 32'h0);
    $display("test either edge done");
    // A hard reset in mid-run must restore the shared pins' defaults.
    xfer(1'b1, 8'hA1, 16'h0005);
    xfer(1'b1, 8'h93, 16'h0001);
    hardRst_n <= 1'b0;
    repeat (8) @(posedge clk);
    hardRst_n <= 1'b1;
    rchk(8'hA1, 32'h01);
    rchk(8'h93, 32'h00);
    xfer(1'b1, 8'h93, 16'h0002);
    xfer(1'b1, 8'h22, 16'h0008);
    $display("test hard reset done");
    xfer(1'b1, 8'hA2, 16'h0088);
    xfer(1'b1, 8'h5D, 16'h0001);
    repeat (4) @(posedge clk);
    chk({30'h0, pinOut[34], pinOe_n[34]}, 32'h2);
    chk({30'h0, pinOut[19], pinOe_n[19]}, 32'h0);
    mainOk <= 1'b0;
    count(200);
    chk({30'h0, pinOut[34], pinOe_n[34]}, 32'h2);
    chk(32'(flips), 32'h0);
    chk({28'h0, pinOut[19], pinOe_n[19], pinOut[27], pinOe_n[27]}, 32'h8);
    slowOn <= 1'b1;
    count(400);
    chk({31'h0, flips >= 8 && flips <= 11}, 32'h1);
    $display("test led done");
    wrap_up();
  end
endmodule : gpio_wake_event_led_bench

// >>> tb/pin_partner.sv
`timescale 1ns/100ps
// External wake sources, LED loads and the slow oscillator.
module pin_partner (
  input wire logic clk,
  input wire logic [35:0] want,
  input wire logic [35:0] pinOut,
  input wire logic [35:0] pinOe_n,
  input wire logic slowOn,
  output logic [35:0] pinIn,
  output logic slowClk
);
  int slowCnt = 0;
  // A pad that the block drives reads back its drive, so LED pads never float.
  assign pinIn = (want & pinOe_n) | (pinOut & ~pinOe_n);
  // The oscillator stands still while absent, as an unfitted crystal would.
  always @(posedge clk) begin
    slowCnt <= slowOn ? (slowCnt + 1) % 10 : 0;
  end
  assign slowClk = slowOn && (slowCnt < 5);
endmodule : pin_partner
